// ### hw/cwp_top.sv
// Command write-protection engine: passwords, permit masks and security level.
`timescale 1ns/1ps
module cwp_top
  import cwp_pkg::*;
(
  input wire logic clk, // System clock, 25 MHz.
  input wire logic sys_rst, // Synchronous reset, active high.
  input wire logic cmd_valid, // Pulse: a command transaction starts.
  input wire logic cmd_rd, // With cmd_valid: 1 read, 0 write.
  input wire logic [7:0] cmd_code, // With cmd_valid: command code.
  input wire logic byte_valid, // Pulse: one write data byte.
  input wire logic [7:0] byte_data, // Write data byte, low byte first.
  input wire logic cmd_stop, // Pulse: transaction ends.
  output logic wr_grant, // Pulse: write accepted.
  output logic wr_deny, // Pulse: write refused.
  output logic [7:0] wr_code, // Code of the judged write.
  output logic rd_ack, // Pulse: read accepted.
  output logic [7:0] level_byte // Security level byte for reads.
);

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    cwp_state_t st;
    logic [1:0] lvl;
    logic [7:0] code;
    logic [5:0] cnt;
    logic ovf;
    logic [MASK_BITS-1:0] dbuf;
    logic [MASK_BITS-1:0] dmask;
    logic [MASK_BITS-1:0] umask;
    logic [PRIV_BITS-1:0] dpriv;
    logic [PRIV_BITS-1:0] upriv;
    logic [PUB_BITS-1:0] upub;
    logic grant;
    logic deny;
    logic ack;
    logic [7:0] gcode;
    logic [7:0] rdat;
  } cwp_regs_t;

  cwp_regs_t r_reg;
  cwp_regs_t r_next;
  logic allow;
  logic fin;
  logic len_ok;
  logic [PRIV_BITS-1:0] priv_in;
  logic [PUB_BITS-1:0] pub_in;

  cwp_gate u_gate (
    .code(r_reg.code),
    .dmask(r_reg.dmask),
    .umask(r_reg.umask),
    .level(r_reg.lvl),
    .allow(allow)
  );

  assign fin = cmd_stop && !cmd_valid && r_reg.st == ST_WRITE;
  assign priv_in = r_reg.dbuf[PRIV_BITS-1:0];
  assign pub_in = r_reg.dbuf[PUB_BITS-1:0];

  always_comb begin
    case (r_reg.code)
      CMD_PRIV: len_ok = !r_reg.ovf && r_reg.cnt == LEN_PRIV;
      CMD_PUB: len_ok = !r_reg.ovf && r_reg.cnt == LEN_PUB;
      CMD_MASK: len_ok = !r_reg.ovf && r_reg.cnt == LEN_MASK;
      default: len_ok = 1'b1;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    r_next = r_reg;
    r_next.grant = 1'b0;
    r_next.deny = 1'b0;
    r_next.ack = 1'b0;
    r_next.rdat = {6'h00, r_reg.lvl};
    if (cmd_valid) begin
      // A new start always wins; an unfinished transaction is dropped.
      r_next.code = cmd_code;
      r_next.cnt = 6'h00;
      r_next.ovf = 1'b0;
      if (cmd_rd) begin
        r_next.st = ST_SKIP;
        r_next.ack = 1'b1;
      end else begin
        r_next.st = ST_WRITE;
      end
    end else begin
      case (r_reg.st)
        ST_WRITE: begin
          if (byte_valid && !cmd_stop) begin
            if (r_reg.cnt < LEN_MASK) begin
              r_next.dbuf[{r_reg.cnt[4:0], 3'b000} +: 8] = byte_data;
              r_next.cnt = r_reg.cnt + 6'h01;
            end else begin
              r_next.ovf = 1'b1;
            end
          end
          if (cmd_stop) begin
            r_next.st = ST_IDLE;
            r_next.gcode = r_reg.code;
            // Nothing below touches state unless the write is accepted.
            if (!allow || !len_ok) begin
              r_next.deny = 1'b1;
            end else begin
              r_next.grant = 1'b1;
              case (r_reg.code)
                CMD_PRIV: begin
                  // Matching only ever raises; a miss by an owner replaces that
                  // owner's password and keeps the level.
                  if (priv_in == r_reg.dpriv) begin
                    r_next.lvl = LVL_3;
                  end else if (priv_in == r_reg.upriv) begin
                    if (r_reg.lvl < LVL_2) begin
                      r_next.lvl = LVL_2;
                    end
                  end else if (r_reg.lvl == LVL_3) begin
                    r_next.dpriv = priv_in;
                  end else if (r_reg.lvl == LVL_2) begin
                    r_next.upriv = priv_in;
                  end
                end
                CMD_PUB: begin
                  if (r_reg.lvl >= LVL_2) begin
                    r_next.upub = pub_in;
                    r_next.lvl = LVL_1;
                  end else if (pub_in == r_reg.upub) begin
                    r_next.lvl = LVL_1;
                  end else begin
                    r_next.lvl = LVL_0;
                  end
                end
                CMD_MASK: begin
                  if (r_reg.lvl == LVL_3) begin
                    r_next.dmask = r_reg.dbuf;
                  end else begin
                    r_next.umask = r_reg.dbuf;
                  end
                end
                default: begin
                end
              endcase
            end
          end
        end
        ST_SKIP: begin
          if (cmd_stop) begin
            r_next.st = ST_IDLE;
          end
        end
        default: begin
          r_next.st = ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      r_reg.st <= ST_IDLE;
      r_reg.lvl <= LVL_RST;
      r_reg.code <= 8'h00;
      r_reg.cnt <= 6'h00;
      r_reg.ovf <= 1'b0;
      r_reg.dbuf <= '0;
      r_reg.dmask <= MASK_RST;
      r_reg.umask <= MASK_RST;
      r_reg.dpriv <= PRIV_RST;
      r_reg.upriv <= PRIV_RST;
      r_reg.upub <= PUB_RST;
      r_reg.grant <= 1'b0;
      r_reg.deny <= 1'b0;
      r_reg.ack <= 1'b0;
      r_reg.gcode <= 8'h00;
      r_reg.rdat <= {6'h00, LVL_RST};
    end else begin
      r_reg <= r_next;
    end
  end

  assign wr_grant = r_reg.grant;
  assign wr_deny = r_reg.deny;
  assign wr_code = r_reg.gcode;
  assign rd_ack = r_reg.ack;
  assign level_byte = r_reg.rdat;

  ////////////////////////////////////////////////////////////////////////////
  // Checks on the protection decisions.
  logic dlock;
  logic ulock;
  logic plain;

  assign dlock = !r_reg.dmask[r_reg.code];
  assign ulock = !r_reg.umask[r_reg.code];
  assign plain = r_reg.code < CMD_LEVEL;

  read_always_a: assert property (@(posedge clk) disable iff (sys_rst)
    cmd_valid && cmd_rd |=> rd_ack && !wr_deny && !wr_grant)
    else $error("read was not acknowledged");

  reset_level_a: assert property (@(posedge clk)
    $past(sys_rst) |-> level_byte == 8'h01)
    else $error("level byte not 01h after reset");

  level_ro_a: assert property (@(posedge clk) disable iff (sys_rst)
    fin && r_reg.code == CMD_LEVEL |=> wr_deny && $stable(r_reg.lvl))
    else $error("level byte accepted a write");

  dflt_lock_a: assert property (@(posedge clk) disable iff (sys_rst)
    fin && plain && dlock && r_reg.lvl != LVL_3 |=> wr_deny ##1 wr_code == $past(r_reg.code, 2))
    else $error("default-locked write passed below level 3");

  user_lock_a: assert property (@(posedge clk) disable iff (sys_rst)
    fin && plain && !dlock && ulock |=> (wr_grant == ($past(r_reg.lvl) >= LVL_2)))
    else $error("user-locked write judged wrongly");

  level_one_a: assert property (@(posedge clk) disable iff (sys_rst)
    fin && plain && !dlock && !ulock && r_reg.lvl == LVL_1 |=> wr_grant && !wr_deny)
    else $error("open command refused at level 1");

  priv_nolower_a: assert property (@(posedge clk) disable iff (sys_rst)
    fin && r_reg.code == CMD_PRIV |=> r_reg.lvl >= $past(r_reg.lvl))
    else $error("private password lowered the level");

  dflt_priv_a: assert property (@(posedge clk) disable iff (sys_rst)
    fin && r_reg.code == CMD_PRIV && len_ok && priv_in == r_reg.dpriv
    |=> r_reg.lvl == LVL_3 ##1 level_byte == 8'h03)
    else $error("default private password did not give level 3");

  pub_low_a: assert property (@(posedge clk) disable iff (sys_rst)
    fin && r_reg.code == CMD_PUB && len_ok |=> r_reg.lvl <= LVL_1)
    else $error("public password left level above 1");

  pub_miss_a: assert property (@(posedge clk) disable iff (sys_rst)
    fin && r_reg.code == CMD_PUB && len_ok && r_reg.lvl < LVL_2 && pub_in != r_reg.upub
    |=> r_reg.lvl == LVL_0)
    else $error("public mismatch did not drop to level 0");

  deny_still_a: assert property (@(posedge clk) disable iff (sys_rst)
    fin && !(allow && len_ok) |=> $stable(r_reg.lvl) && $stable(r_reg.dmask)
    && $stable(r_reg.umask) && $stable(r_reg.dpriv) && $stable(r_reg.upriv)
    && $stable(r_reg.upub))
    else $error("refused write changed protection state");

  answer_once_a: assert property (@(posedge clk) disable iff (sys_rst)
    fin |=> (wr_grant ^ wr_deny) && wr_code == $past(r_reg.code))
    else $error("judged write lacks a single answer");

  no_stray_a: assert property (@(posedge clk) disable iff (sys_rst)
    !fin |=> !wr_grant && !wr_deny)
    else $error("write answer without a judged write");

  pub_match_a: assert property (@(posedge clk) disable iff (sys_rst)
    fin && r_reg.code == CMD_PUB && len_ok && r_reg.lvl < LVL_2 && pub_in == r_reg.upub
    |=> r_reg.lvl == LVL_1)
    else $error("public match did not give level 1");

  user_priv_a: assert property (@(posedge clk) disable iff (sys_rst)
    fin && r_reg.code == CMD_PRIV && len_ok && priv_in == r_reg.upriv |=> r_reg.lvl >= LVL_2)
    else $error("user private password did not give level 2");

  // Level movements are checked as invariants, so that a path added later
  // cannot lift the level above 1 without a private password write, or drop it to 0 without a public password write.
  level_rise_a: assert property (@(posedge clk) disable iff (sys_rst)
    r_reg.lvl < LVL_2 && !(fin && r_reg.code == CMD_PRIV) |=> r_reg.lvl < LVL_2)
    else $error("level above 1 reached without private password");

  level_zero_a: assert property (@(posedge clk) disable iff (sys_rst)
    r_reg.lvl != LVL_0 && !(fin && r_reg.code == CMD_PUB) |=> r_reg.lvl != LVL_0)
    else $error("level 0 reached without public password");

  level_view_a: assert property (@(posedge clk) disable iff (sys_rst)
    level_byte == {6'h00, $past(r_reg.lvl)})
    else $error("level byte does not follow the level");

  dmask_store_a: assert property (@(posedge clk) disable iff (sys_rst)
    fin && allow && len_ok && r_reg.code == CMD_MASK && r_reg.lvl == LVL_3
    |=> r_reg.dmask == $past(r_reg.dbuf) && $stable(r_reg.umask))
    else $error("mask write at level 3 missed the default store");

  umask_store_a: assert property (@(posedge clk) disable iff (sys_rst)
    fin && allow && len_ok && r_reg.code == CMD_MASK && r_reg.lvl == LVL_2
    |=> r_reg.umask == $past(r_reg.dbuf) && $stable(r_reg.dmask))
    else $error("mask write at level 2 missed the user store");

  byte_land_a: assert property (@(posedge clk) disable iff (sys_rst)
    r_reg.st == ST_WRITE && !cmd_valid && byte_valid && !cmd_stop && r_reg.cnt < LEN_MASK
    |=> r_reg.dbuf[{$past(r_reg.cnt[4:0]), 3'b000} +: 8] == $past(byte_data))
    else $error("data byte landed in the wrong place");

  reach_three_c: cover property (@(posedge clk) disable iff (sys_rst)
    r_reg.lvl == LVL_2 ##1 r_reg.lvl == LVL_3);

  drop_zero_c: cover property (@(posedge clk) disable iff (sys_rst)
    r_reg.lvl == LVL_1 ##1 r_reg.lvl == LVL_0);

  user_mask_c: cover property (@(posedge clk) disable iff (sys_rst)
    fin && r_reg.code == CMD_MASK && r_reg.lvl == LVL_2 ##1 wr_grant);

  locked_deny_c: cover property (@(posedge clk) disable iff (sys_rst)
    fin && plain && dlock ##1 wr_deny);

  read_zero_c: cover property (@(posedge clk) disable iff (sys_rst)
    cmd_valid && cmd_rd && r_reg.lvl == LVL_0);

endmodule

// ### hw/cwp_pkg.sv
// Constants and types for the command write-protection block.
// Functional notes
// - Each command's permit bit decides its writes; here CMD_PRIV and CMD_PUB ignore the masks, CMD_MASK needs level 2 or more, CMD_LEVEL is never written.
// - Reads of every command always allowed.
// - Locked command writable only after suitable password.
// - Public and private passwords both change protection.
// - Default and user stores: own mask, private password.
// - Default mask bit cleared needs default private password.
// - User mask bit cleared needs user private password.
// - Security level takes values zero through three.
// - Levels 0,1 public; higher need private password.
// - Private password write never lowers the level.
// - Public password write sets level 0 or 1.
// - Level byte read-only, unprotected, resets to 01h.
// - Below level 2, public mismatch gives level 0, match gives 1; at level 2 or 3 any public write stores it and gives 1.
// - Default private password gives level 3.
// - Level 1 writes need both permit bits set.
// - Mask 256 bits, code 00h at bit zero.
package cwp_pkg;

  localparam logic [7:0] CMD_LEVEL = 8'hfa;
  localparam logic [7:0] CMD_PRIV = 8'hfb;
  localparam logic [7:0] CMD_PUB = 8'hfc;
  localparam logic [7:0] CMD_MASK = 8'hfd;

  localparam int PRIV_BITS = 72;
  localparam int PUB_BITS = 32;
  localparam int MASK_BITS = 256;
  localparam int BUF_BYTES = 32;

  localparam logic [5:0] LEN_PRIV = 6'h09;
  localparam logic [5:0] LEN_PUB = 6'h04;
  localparam logic [5:0] LEN_MASK = 6'h20;

  localparam logic [1:0] LVL_0 = 2'h0;
  localparam logic [1:0] LVL_1 = 2'h1;
  localparam logic [1:0] LVL_2 = 2'h2;
  localparam logic [1:0] LVL_3 = 2'h3;
  localparam logic [1:0] LVL_RST = 2'h1;

  localparam logic [MASK_BITS-1:0] MASK_RST = {MASK_BITS{1'b1}};
  localparam logic [PRIV_BITS-1:0] PRIV_RST = '0;
  localparam logic [PUB_BITS-1:0] PUB_RST = '0;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WRITE = 3'b010,
    ST_SKIP = 3'b100
  } cwp_state_t;

endpackage

// ### hw/cwp_gate.sv
// Decides from the two permit masks whether a command write is allowed.
`timescale 1ns/1ps
module cwp_gate
  import cwp_pkg::*;
(
  input wire logic [7:0] code, // Command code of the write.
  input wire logic [MASK_BITS-1:0] dmask, // Default-store permit mask.
  input wire logic [MASK_BITS-1:0] umask, // User-store permit mask.
  input wire logic [1:0] level, // Present security level.
  output logic allow // Write may proceed.
);

  logic [MASK_BITS-1:0] dhit;
  logic [MASK_BITS-1:0] uhit;
  logic [1:0] need;

  // Bit i guards command code i, so code 00h is the lowest bit.
  for (genvar i = 0; i < MASK_BITS; i++) begin : g_bit
    assign dhit[i] = (code == 8'(i)) & ~dmask[i];
    assign uhit[i] = (code == 8'(i)) & ~umask[i];
  end

  always_comb begin
    if (code == CMD_PRIV || code == CMD_PUB) begin
      need = LVL_0;
    end else if (|dhit) begin
      need = LVL_3;
    end else if (|uhit || code == CMD_MASK) begin
      need = LVL_2;
    end else begin
      need = LVL_1;
    end
  end

  // The level byte itself never takes a write.
  assign allow = (code != CMD_LEVEL) && (level >= need);

endmodule

// ### tb/cwp_host.sv
// Host model that issues command reads and writes to the protection block.
`timescale 1ns/1ps
module cwp_host
  import cwp_pkg::*;
(
  input wire logic clk, // System clock.
  output logic cmd_valid, // Transaction start pulse.
  output logic cmd_rd, // Read when high.
  output logic [7:0] cmd_code, // Command code.
  output logic byte_valid, // Data byte pulse.
  output logic [7:0] byte_data, // Data byte, low byte first.
  output logic cmd_stop, // Transaction end pulse.
  input wire logic wr_grant, // Write accepted.
  input wire logic wr_deny, // Write refused.
  input wire logic rd_ack // Read accepted.
);
  initial begin
    cmd_valid = 1'b0;
    cmd_rd = 1'b0;
    cmd_code = 8'h00;
    byte_valid = 1'b0;
    byte_data = 8'h00;
    cmd_stop = 1'b0;
  end

  // Returns {grant, deny, ack} seen in a short bounded window; all zero means no answer.
  // Idle code and data lines toggle so that a stale value is never mistaken for a new one.
  task automatic xfer(input logic rd, input logic [7:0] code, input int n,
                      input logic [255:0] data, output logic [2:0] res);
    res = 3'h0;
    @(posedge clk);
    #1;
    cmd_valid = 1'b1;
    cmd_rd = rd;
    cmd_code = code;
    for (int k = 0; k < n; k++) begin
      @(posedge clk);
      #1;
      cmd_valid = 1'b0;
      cmd_code = ~code;
      byte_valid = 1'b1;
      byte_data = data[8*k +: 8];
    end
    @(posedge clk);
    #1;
    cmd_valid = 1'b0;
    cmd_code = ~code;
    byte_valid = 1'b0;
    byte_data = ~byte_data;
    cmd_stop = !rd;
    for (int w = 0; w < 3; w++) begin
      res = res | {wr_grant, wr_deny, rd_ack};
      @(posedge clk);
      #1;
      cmd_stop = 1'b0;
    end
  endtask
endmodule

// ### tb/cwp_top_tb_top.sv
// Self-checking testbench for the command write-protection block.
`timescale 1ns/1ps
module cwp_top_tb_top
  import cwp_pkg::*;
;
  logic clk;
  logic sys_rst;
  logic cmd_valid, cmd_rd, byte_valid, cmd_stop;
  logic [7:0] cmd_code, byte_data;
  logic wr_grant, wr_deny, rd_ack;
  logic [7:0] wr_code, level_byte;
  int num_errors = 0;
  int samples_checked = 0;

  cwp_top u_cwp_top (.clk(clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd_rd(cmd_rd),
    .cmd_code(cmd_code), .byte_valid(byte_valid), .byte_data(byte_data), .cmd_stop(cmd_stop),
    .wr_grant(wr_grant), .wr_deny(wr_deny), .wr_code(wr_code), .rd_ack(rd_ack),
    .level_byte(level_byte));

  cwp_host u_cwp_host (.clk(clk), .cmd_valid(cmd_valid), .cmd_rd(cmd_rd), .cmd_code(cmd_code),
    .byte_valid(byte_valid), .byte_data(byte_data), .cmd_stop(cmd_stop),
    .wr_grant(wr_grant), .wr_deny(wr_deny), .rd_ack(rd_ack));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic stop_test();
    $display("errors %0d, checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic check_res(input string what, input logic [2:0] exp, input logic [2:0] got);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // A write is judged by grant or deny alone; wr_code must name the judged command.
  task automatic wr(input logic [7:0] c, input int n, input logic [255:0] d, input logic g);
    logic [2:0] r;
    u_cwp_host.xfer(1'b0, c, n, d, r);
    check_res("write answer", {g, !g, 1'b0}, r);
    check_byte("wr_code", c, wr_code);
  endtask

  task automatic rd(input logic [7:0] c);
    logic [2:0] r;
    u_cwp_host.xfer(1'b1, c, 0, 256'h0, r);
    check_res("read answer", 3'h1, r);
  endtask

  task automatic lvl(input logic [1:0] l);
    check_byte("level_byte", {6'h00, l}, level_byte);
  endtask

  task automatic done(input string name);
    $display("test %s done, errors so far %0d", name, num_errors);
  endtask

  initial begin
    logic [255:0] dmask;
    logic [255:0] umask;
    dmask = ~(256'h1 << 8'h10);
    umask = ~(256'h1 << 8'h20);
    sys_rst = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    lvl(LVL_RST);
    rd(CMD_LEVEL);
    wr(8'h10, 1, 256'h5a, 1'b1);
    wr(CMD_LEVEL, 1, 256'h03, 1'b0);
    lvl(LVL_1);
    done("reset_and_level_1");
    wr(CMD_PUB, 4, 256'h44332211, 1'b1);
    lvl(LVL_0);
    wr(8'h10, 1, 256'h5a, 1'b0);
    rd(8'h10);
    wr(CMD_PUB, 3, 256'h0, 1'b0);
    lvl(LVL_0);
    wr(CMD_PUB, 4, 256'h0, 1'b1);
    lvl(LVL_1);
    done("public_password");
    wr(CMD_PRIV, 9, 256'h0, 1'b1);
    lvl(LVL_3);
    wr(CMD_MASK, 32, dmask, 1'b1);
    wr(CMD_PRIV, 9, {184'h0, {9{8'h55}}}, 1'b1);
    lvl(LVL_3);
    wr(CMD_PUB, 4, 256'h0, 1'b1);
    lvl(LVL_1);
    wr(8'h10, 1, 256'h5a, 1'b0);
    done("default_store");
    wr(CMD_PRIV, 9, 256'h0, 1'b1);
    lvl(LVL_2);
    wr(8'h10, 1, 256'h5a, 1'b0);
    wr(CMD_MASK, 32, umask, 1'b1);
    wr(8'h20, 1, 256'h5a, 1'b1);
    wr(CMD_PUB, 4, 256'h0, 1'b1);
    lvl(LVL_1);
    wr(8'h20, 1, 256'h5a, 1'b0);
    wr(8'h21, 1, 256'h5a, 1'b1);
    done("user_store");
    wr(CMD_PRIV, 9, 256'h0, 1'b1);
    lvl(LVL_2);
    wr(CMD_PRIV, 9, {184'h0, {9{8'h55}}}, 1'b1);
    lvl(LVL_3);
    wr(8'h10, 1, 256'h5a, 1'b1);
    wr(CMD_PRIV, 9, 256'h0, 1'b1);
    lvl(LVL_3);
    rd(8'h10);
    done("level_3");
    stop_test();
  end
endmodule
